// >>> design/hwcu_defs.vh
`ifndef HWCU_DEFS_VH
`define HWCU_DEFS_VH

// ************************************************************
// clock and watchdog timing
// ************************************************************
`define HWCU_CLK_PERIOD_NS 50
`define HWCU_TICK_NS 100000000
`define HWCU_TICK_W 21

// ************************************************************
// register byte offsets
// ************************************************************
`define HWCU_OFS_ADDR 8'h00
`define HWCU_OFS_CMD 8'h04
`define HWCU_OFS_RHEAD 8'h08
`define HWCU_OFS_RDATA 8'h0c
`define HWCU_OFS_WSTAT 8'h10
`define HWCU_OFS_ISTAT 8'h14
`define HWCU_OFS_IMASK 8'h18
`define HWCU_OFS_MAP0 8'h20
`define HWCU_MAP_IDX_W 3
`define HWCU_NUM_PORTS 6

// ************************************************************
// command word fields
// ************************************************************
`define HWCU_CMD_ADDR_HI 7
`define HWCU_CMD_ADDR_LO 0
`define HWCU_CMD_OP_HI 10
`define HWCU_CMD_OP_LO 8
`define HWCU_CMD_EN_HI 15
`define HWCU_CMD_EN_LO 12
`define HWCU_CMD_ARG_HI 23
`define HWCU_CMD_ARG_LO 16
`define HWCU_CMD_BCAST 24
`define HWCU_CMD_ERR 25

// ************************************************************
// command opcodes
// ************************************************************
`define HWCU_OP_RD_STATUS 3'h0
`define HWCU_OP_CLR_TIMEOUT 3'h1
`define HWCU_OP_RD_TIMEOUT 3'h2
`define HWCU_OP_SET_WD 3'h3
`define HWCU_OP_HOST_ALIVE 3'h4
`define HWCU_OP_RD_LINKS 3'h5

// ************************************************************
// response encoding
// ************************************************************
`define HWCU_DELIM_OK 8'h21
`define HWCU_DELIM_BAD 8'h3f
`define HWCU_DIGITS_NONE 4'h0
`define HWCU_DIGITS_STATUS 4'h2
`define HWCU_DIGITS_TIMEOUT 4'h3
`define HWCU_DIGITS_LINKS 4'h4
`define HWCU_ST_EN_BIT 7
`define HWCU_ST_TO_BIT 2
`define HWCU_EN_DIGIT_OFF 4'h0
`define HWCU_EN_DIGIT_ON 4'h1

// ************************************************************
// interrupt bits and reset values
// ************************************************************
`define HWCU_IRQ_TIMEOUT 0
`define HWCU_IRQ_RESP 1
`define HWCU_IRQ_W 2
`define HWCU_RST_ADDR 8'h01
`define HWCU_RST_TENTHS 8'h00

`endif

// >>> design/hwcu_top.v
// Functional notes
// - a read-alarm-links command on a valid port answers first with the port's high-alarm map, bit n for channel n.
// - the same answer then carries the port's low-alarm map, bit n for channel n.
// - a read-alarm-links command on a missing port, or any invalid command, answers with the invalid delimiter and the own address.
// - no answer at all on a syntax or communication error or on a foreign address.
// - the broadcast host-alive message is taken by every module and never answered.
// - read-status answers a byte with bit 7 set when the watchdog is enabled and bit 2 set after a timeout.
// - the timeout indication is held until the clear-timeout command, and nothing else, clears it.
// - clear-timeout clears the timeout flag and answers with the valid delimiter and the address only.
// - read-timeout answers one enable digit followed by the two-digit timeout value.
// - the timeout value counts tenths of a second, 01 for 0.1 s up to FF for 25.5 s.
// - set-watchdog stores the enable digit and the timeout and answers valid with the address.
// - the enable digit is 1 for enabled and 0 for disabled, in the set command and in the answer.
// - addresses span 00 to FF and every answer echoes the module's own address.
// - accepted commands answer with the valid delimiter, rejected ones with the invalid one.
// - a watchdog timeout disables the watchdog until the host sets it again.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "hwcu_defs.vh"

module hwcu_top #(
    parameter TICK_CYCLES = `HWCU_TICK_NS / `HWCU_CLK_PERIOD_NS
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg irq,
    output reg wd_timeout
);

    localparam integer TICK_LAST_I = TICK_CYCLES - 1;
    localparam [`HWCU_TICK_W-1:0] TICK_LAST = TICK_LAST_I[`HWCU_TICK_W-1:0];

    // ************************************************************
    // bus address phase capture
    // ************************************************************
    reg ap_valid_q, ap_write_q, ap_low_q;
    reg [7:0] ap_addr_q;
    wire ap_take;
    assign ap_take = hsel & hready & htrans[1];

    // address phase latched for the following data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_low_q <= 1'b0;
            ap_addr_q <= 8'h00;
        end else if (hready) begin
            ap_valid_q <= ap_take;
            ap_write_q <= hwrite;
            ap_low_q <= (haddr[31:8] == 24'h000000);
            ap_addr_q <= haddr[7:0];
        end
    end

    wire wr_hit, wr_addr, wr_cmd, wr_istat, wr_imask;
    assign wr_hit = ap_valid_q & ap_write_q & ap_low_q;
    assign wr_addr = wr_hit & (ap_addr_q == `HWCU_OFS_ADDR);
    assign wr_cmd = wr_hit & (ap_addr_q == `HWCU_OFS_CMD);
    assign wr_istat = wr_hit & (ap_addr_q == `HWCU_OFS_ISTAT);
    assign wr_imask = wr_hit & (ap_addr_q == `HWCU_OFS_IMASK);

    // ************************************************************
    // module address and alarm link tables
    // ************************************************************
    reg [7:0] own_addr_q;
    wire [7:0] hi_map [0:`HWCU_NUM_PORTS-1];
    wire [7:0] lo_map [0:`HWCU_NUM_PORTS-1];

    // own module address, any value 00 to ff
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            own_addr_q <= `HWCU_RST_ADDR;
        end else if (wr_addr) begin
            own_addr_q <= hwdata[7:0];
        end
    end

    // one link word per output port: low byte high alarms, next byte low alarms
    genvar gi;
    generate
        for (gi = 0; gi < `HWCU_NUM_PORTS; gi = gi + 1) begin : g_port
            reg [15:0] map_q;
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    map_q <= 16'h0000;
                end else if (wr_hit && ap_addr_q == (`HWCU_OFS_MAP0 + gi * 4)) begin
                    map_q <= hwdata[15:0];
                end
            end
            assign hi_map[gi] = map_q[7:0];
            assign lo_map[gi] = map_q[15:8];
        end
    endgenerate

    // ************************************************************
    // command decode
    // ************************************************************
    wire [7:0] c_addr;
    wire [2:0] c_op;
    wire [3:0] c_en;
    wire [7:0] c_arg;
    wire c_bcast, c_err, c_port_ok, c_mine, host_alive, en_digit_ok;
    wire [`HWCU_MAP_IDX_W-1:0] c_port;
    assign c_addr = hwdata[`HWCU_CMD_ADDR_HI:`HWCU_CMD_ADDR_LO];
    assign c_op = hwdata[`HWCU_CMD_OP_HI:`HWCU_CMD_OP_LO];
    assign c_en = hwdata[`HWCU_CMD_EN_HI:`HWCU_CMD_EN_LO];
    assign c_arg = hwdata[`HWCU_CMD_ARG_HI:`HWCU_CMD_ARG_LO];
    assign c_bcast = hwdata[`HWCU_CMD_BCAST];
    assign c_err = hwdata[`HWCU_CMD_ERR];
    assign c_port = c_arg[`HWCU_MAP_IDX_W-1:0];
    assign c_port_ok = (c_arg < `HWCU_NUM_PORTS);
    // addressed to this module, and free of framing faults
    assign c_mine = wr_cmd & ~c_err & ~c_bcast & (c_addr == own_addr_q);
    // broadcast host-alive is taken regardless of address
    assign host_alive = wr_cmd & ~c_err & c_bcast & (c_op == `HWCU_OP_HOST_ALIVE);
    assign en_digit_ok = (c_en == `HWCU_EN_DIGIT_OFF) | (c_en == `HWCU_EN_DIGIT_ON);

    // ************************************************************
    // watchdog state
    // ************************************************************
    reg wd_en_q, wd_to_q;
    reg [7:0] wd_tenths_q, wd_cnt_q;
    reg [`HWCU_TICK_W-1:0] tick_cnt_q;
    wire tick, expire, do_clear, do_set;
    assign do_clear = c_mine & (c_op == `HWCU_OP_CLR_TIMEOUT);
    assign do_set = c_mine & (c_op == `HWCU_OP_SET_WD) & en_digit_ok;
    assign tick = (tick_cnt_q == TICK_LAST);
    // full count of tenths ends the wait; zero timeout never expires
    assign expire = wd_en_q & tick & (wd_tenths_q != 8'h00) &
                    ((wd_cnt_q + 8'h01) == wd_tenths_q);

    // tenth-of-a-second prescaler, restarted by host-alive
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_q <= {`HWCU_TICK_W{1'b0}};
        end else if (tick || host_alive || !wd_en_q) begin
            tick_cnt_q <= {`HWCU_TICK_W{1'b0}};
        end else begin
            tick_cnt_q <= tick_cnt_q + {{(`HWCU_TICK_W-1){1'b0}}, 1'b1};
        end
    end

    // elapsed tenths since the last host-alive
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_cnt_q <= 8'h00;
        end else if (host_alive || do_set || !wd_en_q || expire) begin
            wd_cnt_q <= 8'h00;
        end else if (tick) begin
            wd_cnt_q <= wd_cnt_q + 8'h01;
        end
    end

    // enable and timeout value, expiry drops the enable
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_en_q <= 1'b0;
            wd_tenths_q <= `HWCU_RST_TENTHS;
        end else if (expire) begin
            wd_en_q <= 1'b0;
        end else if (do_set) begin
            wd_en_q <= (c_en == `HWCU_EN_DIGIT_ON);
            wd_tenths_q <= c_arg;
        end
    end

    // sticky timeout flag, only clear-timeout removes it; set wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_to_q <= 1'b0;
        end else if (expire) begin
            wd_to_q <= 1'b1;
        end else if (do_clear) begin
            wd_to_q <= 1'b0;
        end
    end

    // ************************************************************
    // response build
    // ************************************************************
    reg resp_ok;
    reg [3:0] resp_digits;
    reg [15:0] resp_pay;
    wire [7:0] st_byte;

    assign st_byte = {wd_en_q, 4'h0, wd_to_q, 2'b00};

    // delimiter, digit count and payload per opcode
    always @* begin
        resp_ok = 1'b1;
        resp_digits = `HWCU_DIGITS_NONE;
        resp_pay = 16'h0000;
        case (c_op)
            `HWCU_OP_RD_STATUS: begin
                resp_digits = `HWCU_DIGITS_STATUS;
                resp_pay = {8'h00, st_byte};
            end
            `HWCU_OP_CLR_TIMEOUT: begin
                resp_ok = 1'b1;
            end
            `HWCU_OP_RD_TIMEOUT: begin
                resp_digits = `HWCU_DIGITS_TIMEOUT;
                resp_pay = {4'h0, 3'b000, wd_en_q, wd_tenths_q};
            end
            `HWCU_OP_SET_WD: begin
                resp_ok = en_digit_ok;
            end
            `HWCU_OP_RD_LINKS: begin
                if (c_port_ok) begin
                    resp_digits = `HWCU_DIGITS_LINKS;
                    resp_pay = {hi_map[c_port], lo_map[c_port]};
                end else begin
                    resp_ok = 1'b0;
                end
            end
            default: begin
                resp_ok = 1'b0;
            end
        endcase
    end

    reg resp_pend_q;
    reg [7:0] resp_delim_q;
    reg [7:0] resp_addr_q;
    reg [3:0] resp_digits_q;
    reg [15:0] resp_pay_q;

    // answer latched on each addressed command, pending flag dropped by any other command
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp_pend_q <= 1'b0;
            resp_delim_q <= 8'h00;
            resp_addr_q <= 8'h00;
            resp_digits_q <= 4'h0;
            resp_pay_q <= 16'h0000;
        end else if (c_mine) begin
            resp_pend_q <= 1'b1;
            resp_delim_q <= resp_ok ? `HWCU_DELIM_OK : `HWCU_DELIM_BAD;
            resp_addr_q <= own_addr_q;
            resp_digits_q <= resp_ok ? resp_digits : `HWCU_DIGITS_NONE;
            resp_pay_q <= resp_ok ? resp_pay : 16'h0000;
        end else if (wr_cmd) begin
            resp_pend_q <= 1'b0;
        end
    end

    // ************************************************************
    // interrupts
    // ************************************************************
    reg [`HWCU_IRQ_W-1:0] istat_q, imask_q;
    wire [`HWCU_IRQ_W-1:0] ievt, iclr;
    assign ievt = {c_mine, expire};
    assign iclr = wr_istat ? hwdata[`HWCU_IRQ_W-1:0] : {`HWCU_IRQ_W{1'b0}};

    // sticky status, write one to clear, new event wins
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat_q <= {`HWCU_IRQ_W{1'b0}};
            imask_q <= {`HWCU_IRQ_W{1'b0}};
            irq <= 1'b0;
            wd_timeout <= 1'b0;
        end else begin
            istat_q <= (istat_q & ~iclr) | ievt;
            if (wr_imask) begin
                imask_q <= hwdata[`HWCU_IRQ_W-1:0];
            end
            irq <= |(((istat_q & ~iclr) | ievt) & (wr_imask ? hwdata[`HWCU_IRQ_W-1:0] : imask_q));
            wd_timeout <= expire | (wd_to_q & ~do_clear);
        end
    end

    // ************************************************************
    // read data and bus answer
    // ************************************************************
    reg [31:0] rd_mux;
    wire [7:0] ra;
    wire [`HWCU_MAP_IDX_W-1:0] ra_port;

    assign ra = haddr[7:0];
    assign ra_port = ra[`HWCU_MAP_IDX_W+1:2];

    // read value chosen in the address phase
    always @* begin
        rd_mux = 32'h00000000;
        if (haddr[31:8] == 24'h000000) begin
            case (ra)
                `HWCU_OFS_ADDR: rd_mux = {24'h000000, own_addr_q};
                `HWCU_OFS_RHEAD: rd_mux = {11'h000, resp_pend_q, resp_digits_q,
                                           resp_addr_q, resp_delim_q};
                `HWCU_OFS_RDATA: rd_mux = {16'h0000, resp_pay_q};
                `HWCU_OFS_WSTAT: rd_mux = {15'h0000, wd_tenths_q, wd_cnt_q, st_byte[7:0] == 8'h00 ?
                                           1'b0 : 1'b1};
                `HWCU_OFS_ISTAT: rd_mux = {30'h00000000, istat_q};
                `HWCU_OFS_IMASK: rd_mux = {30'h00000000, imask_q};
                default: begin
                    if (ra >= `HWCU_OFS_MAP0 && ra[1:0] == 2'b00 &&
                        ra_port < `HWCU_NUM_PORTS && ra < 8'h40) begin
                        rd_mux = {16'h0000, lo_map[ra_port], hi_map[ra_port]};
                    end
                end
            endcase
        end
    end

    // zero-wait slave, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (ap_take && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

endmodule

// >>> sim/hwcu_chk_asserts.sv
`timescale 1ns/100ps
`include "hwcu_defs.vh"
module hwcu_chk #(
    parameter TICK_CYCLES = 10
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hready,
    input wire [31:0] hwdata,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire irq,
    input wire wd_timeout
);
    // ****************************************
    // bus decode and event counters
    // ****************************************
    wire ap = hsel & hready & htrans[1];
    wire [2:0] op = hwdata[`HWCU_CMD_OP_HI:`HWCU_CMD_OP_LO];
    wire rst_cnt = (op == `HWCU_OP_SET_WD) || (op == `HWCU_OP_HOST_ALIVE);
    reg wr_q;
    reg cmd_q;
    reg [1:0] clr_q;
    reg [1:0] wrc_q;
    reg [31:0] since_q;
    // data-phase flags and recent-event windows
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            cmd_q <= 1'b0;
            clr_q <= 2'h0;
            wrc_q <= 2'h0;
            since_q <= 32'h0;
        end else begin
            wr_q <= ap & hwrite;
            cmd_q <= ap & hwrite & (haddr == 32'h4);
            clr_q <= (cmd_q && op == `HWCU_OP_CLR_TIMEOUT) ? 2'h3 : clr_q - {1'b0, |clr_q};
            wrc_q <= wr_q ? 2'h3 : wrc_q - {1'b0, |wrc_q};
            if (cmd_q && rst_cnt) begin
                since_q <= 32'h0;
            end else if (since_q < 32'h00100000) begin
                since_q <= since_q + 32'h1;
            end
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_ready_high: assert property (hreadyout) else $error("wait state inserted");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_zero_wait: assert property (ap |=> hreadyout [*2]) else $error("transfer stalled");
    a_rdata_holds: assert property (!(ap && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without read");
    a_flag_sticky: assert property ($fell(wd_timeout) |-> clr_q != 2'h0)
        else $error("timeout flag dropped without clear");
    a_expiry_wait: assert property ($rose(wd_timeout) |-> since_q >= TICK_CYCLES)
        else $error("timeout flag too early");
    a_irq_cause: assert property ($rose(irq) |-> wrc_q != 2'h0 || wd_timeout)
        else $error("interrupt without event");
    a_irq_release: assert property ($fell(irq) |-> wrc_q != 2'h0)
        else $error("interrupt dropped without write");

    c_expiry: cover property ($rose(wd_timeout));
    c_irq_drop: cover property ($fell(irq));
    c_alive: cover property (cmd_q && op == `HWCU_OP_HOST_ALIVE);
endmodule

bind hwcu_top hwcu_chk #(.TICK_CYCLES(TICK_CYCLES)) hwcu_chk_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .wd_timeout(wd_timeout));

// >>> sim/hwcu_host.sv
`timescale 1ns/100ps
module hwcu_host (
    input wire hclk,
    input wire hready,
    input wire [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // ****************************************
    // host side: bus master and command words
    // ****************************************
    logic [31:0] rdat;
    event got;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // command word: target, opcode, enable digit, argument, broadcast, frame error
    function automatic logic [31:0] cmd(input logic [7:0] ad, input logic [2:0] op,
        input logic [3:0] en, input logic [7:0] arg, input logic bc, input logic er);
        cmd = {6'h0, er, bc, arg, en, 1'b0, op, ad};
    endfunction
    // one single word transfer, address phase then data phase
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        hwdata <= ~d; // released data no longer shows the old value
        rdat = hrdata;
        if (!w) ->got;
    endtask
endmodule

// >>> sim/tb.sv
`timescale 1ns/100ps
`include "hwcu_defs.vh"
module tb;
    // ****************************************
    // clock, reset, design and host
    // ****************************************
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    wire hsel;
    wire [31:0] haddr;
    wire [1:0] htrans;
    wire hwrite;
    wire [2:0] hsize;
    wire [31:0] hwdata;
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    wire irq;
    wire wd_timeout;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    logic [31:0] r;
    logic [7:0] own;
    logic [7:0] j;
    int n;
    int bad_count = 0;
    int n_checks = 0;
    always #25 hclk = ~hclk;

    hwcu_top #(.TICK_CYCLES(10)) hwcu_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
        .wd_timeout(wd_timeout));
    hwcu_host host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
            bad_count++;
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task wr(input logic [31:0] a, input logic [31:0] d);
        host_i.xfer(1'b1, a, d);
    endtask
    // note the expectation, then read
    task rx(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e & m});
        host_i.xfer(1'b0, a, 32'h0);
    endtask
    task run(input logic [7:0] ad, input logic [2:0] op, input logic [3:0] en,
        input logic [7:0] arg, input logic bc, input logic er);
        wr(`HWCU_OFS_CMD, host_i.cmd(ad, op, en, arg, bc, er));
    endtask
    // answer header and payload for the own address
    task ans(input logic [3:0] dg, input logic [7:0] dl, input logic [15:0] pay);
        rx(`HWCU_OFS_RHEAD, {11'h0, 1'b1, dg, own, dl}, 32'hffffffff);
        if (dg != 4'h0) rx(`HWCU_OFS_RDATA, {16'h0, pay}, 32'hffffffff);
    endtask
    // monitor compares each read with the oldest note
    always @(host_i.got) begin
        note = exp_q.pop_front();
        chk(host_i.rdat & note[63:32], note[31:0]);
    end
    initial begin
        #(20000 * 50);
        bad_count++;
        print_verdict;
    end

    initial begin
        void'($urandom(32'hdbca9015));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        own = 8'h01;
        rx(`HWCU_OFS_ADDR, 32'h1, 32'hffffffff);
        r = $urandom;
        own = r[7:0];
        wr(`HWCU_OFS_ADDR, {24'h0, own});
        run(own, 3'h0, 4'h0, 8'h0, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_STATUS, `HWCU_DELIM_OK, 16'h0);
        run(own ^ 8'h01, 3'h0, 4'h0, 8'h0, 1'b0, 1'b0);
        rx(`HWCU_OFS_RHEAD, 32'h0, 32'h00100000);
        run(own, 3'h0, 4'h0, 8'h0, 1'b0, 1'b1);
        rx(`HWCU_OFS_RHEAD, 32'h0, 32'h00100000);
        for (j = 0; j < 8; j++) begin
            r = $urandom;
            if (j < 6) wr(`HWCU_OFS_MAP0 + {22'h0, j, 2'h0}, {16'h0, r[15:0]});
            run(own, 3'h5, 4'h0, j, 1'b0, 1'b0);
            if (j < 6) ans(`HWCU_DIGITS_LINKS, `HWCU_DELIM_OK, {r[7:0], r[15:8]});
            else ans(`HWCU_DIGITS_NONE, `HWCU_DELIM_BAD, 16'h0);
        end
        run(own, 3'h5, 4'h0, 8'hff, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_NONE, `HWCU_DELIM_BAD, 16'h0);
        // host-alive opcode sent to one address is refused like 6 and 7
        for (j = 4; j < 8; j = j + ((j == 8'h04) ? 8'h02 : 8'h01)) begin
            run(own, j[2:0], 4'h0, 8'h0, 1'b0, 1'b0);
            ans(`HWCU_DIGITS_NONE, `HWCU_DELIM_BAD, 16'h0);
        end
        // broadcast of the read-status opcode is dropped silently
        run(8'h00, 3'h0, 4'h0, 8'h0, 1'b1, 1'b0);
        rx(`HWCU_OFS_RHEAD, 32'h0, 32'h00100000);
        // limits of the timeout value, 01 set disabled so it cannot expire
        for (j = 8'h01; j != 8'h00; j = (j == 8'h01) ? 8'hff : 8'h00) begin
            run(own, 3'h3, {3'h0, j[7]}, j, 1'b0, 1'b0);
            ans(`HWCU_DIGITS_NONE, `HWCU_DELIM_OK, 16'h0);
            run(own, 3'h2, 4'h0, 8'h0, 1'b0, 1'b0);
            ans(`HWCU_DIGITS_TIMEOUT, `HWCU_DELIM_OK, {7'h00, j[7], j});
        end
        run(own, 3'h3, 4'h2, 8'h05, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_NONE, `HWCU_DELIM_BAD, 16'h0);
        run(own, 3'h3, 4'h0, 8'h01, 1'b0, 1'b0);
        run(own, 3'h0, 4'h0, 8'h0, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_STATUS, `HWCU_DELIM_OK, 16'h0);
        // keep-alive holds off expiry, then silence lets it expire
        run(own, 3'h3, 4'h1, 8'h03, 1'b0, 1'b0);
        run(own, 3'h0, 4'h0, 8'h0, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_STATUS, `HWCU_DELIM_OK, 16'h80);
        for (j = 0; j < 12; j++) begin
            run(8'h00, `HWCU_OP_HOST_ALIVE, 4'h0, 8'h0, 1'b1, 1'b0);
            if (j == 5) rx(`HWCU_OFS_RHEAD, 32'h0, 32'h00100000);
        end
        chk({31'h0, wd_timeout}, 32'h0);
        n = 0;
        while (wd_timeout !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n++;
        end
        chk({31'h0, n >= 29 && n <= 34}, 32'h1);
        run(own, 3'h0, 4'h0, 8'h0, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_STATUS, `HWCU_DELIM_OK, 16'h04);
        run(own, 3'h2, 4'h0, 8'h0, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_TIMEOUT, `HWCU_DELIM_OK, 16'h0003);
        run(8'h00, `HWCU_OP_HOST_ALIVE, 4'h0, 8'h0, 1'b1, 1'b0);
        run(own, 3'h0, 4'h0, 8'h0, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_STATUS, `HWCU_DELIM_OK, 16'h04);
        // interrupt raised, timeout status bit cleared, then response bit masked
        wr(`HWCU_OFS_IMASK, 32'h3);
        repeat (2) @(posedge hclk);
        #1 chk({31'h0, irq}, 32'h1);
        rx(`HWCU_OFS_ISTAT, 32'h3, 32'hffffffff);
        wr(`HWCU_OFS_ISTAT, 32'h1);
        rx(`HWCU_OFS_ISTAT, 32'h2, 32'hffffffff);
        wr(`HWCU_OFS_IMASK, 32'h1);
        repeat (2) @(posedge hclk);
        #1 chk({31'h0, irq}, 32'h0);
        run(own, 3'h1, 4'h0, 8'h0, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_NONE, `HWCU_DELIM_OK, 16'h0);
        run(own, 3'h0, 4'h0, 8'h0, 1'b0, 1'b0);
        ans(`HWCU_DIGITS_STATUS, `HWCU_DELIM_OK, 16'h00);
        chk({31'h0, wd_timeout}, 32'h0);
        for (j = 0; j < 2; j++) begin
            own = {8{j[0]}};
            wr(`HWCU_OFS_ADDR, {24'h0, own});
            run(own, 3'h0, 4'h0, 8'h0, 1'b0, 1'b0);
            ans(`HWCU_DIGITS_STATUS, `HWCU_DELIM_OK, 16'h00);
        end
        wr(32'h40, 32'hffffffff);
        rx(32'h40, 32'h0, 32'hffffffff);
        rx(`HWCU_OFS_CMD, 32'h0, 32'hffffffff);
        print_verdict;
    end
endmodule
